// >>> cct_timer.sv
// How it works
// R1 - a 16-bit free-running up-counter advanced by the prescaler tick
// R2 - internal clock divided by 2, 4 or 8 feeds the counter
// R3 - select 00 gives /4, 01 gives /2, 10 gives /8, 11 external
// R4 - writing either counter low byte reloads the counter with fffc
// R5 - both counter pairs read the same; alternate low never clears overflow
// R6 - high byte read first buffers the low byte until the low read
// R7 - a low read outside a sequence returns the live low byte
// R8 - a wrap from ffff to 0000 sets the overflow flag
// R9 - overflow interrupt only with enable and its route or global route
// R10 - overflow flag clears after status read then counter low access
// R11 - counting continues in wait, stops in halt, reset restarts it
// R12 - reset loads the counter with fffc
// R13 - external pin counts only when select is 11, on chosen edge
// R14 - counter updates synchronous to the core clock edge
// R15 - external clock edges at least four core clocks apart
// R16 - each capture pin edge latches the count and sets its flag
// R17 - each capture channel has its own rising or falling edge select
// R18 - capture interrupt only with enable and its route or global route
// R19 - capture flag clears after status read then capture low access
// R20 - a capture high read blocks transfers until the low read
// R21 - capture registers are read-only and hold the latest capture
// R22 - three separate interrupts, or one global interrupt replacing them; the compare interrupt is tied low and never fires
`timescale 1ns/100ps
module cct_timer (
  input  wire logic              i_sys_clk,
  input  wire logic              i_srst,
  input  wire cct_pkg::cct_cfg_s i_cfg,
  input  wire cct_pkg::cct_acc_s i_acc,
  input  wire logic              i_halt,
  input  wire logic              i_external_count_input,
  input  wire logic [1:0]        i_capture_pin_n,
  output logic [7:0]             o_rd_data,
  output logic                   o_rd_valid,
  output logic [15:0]            o_count,
  output logic                   o_overflow_flag,
  output logic [1:0]             o_capture_flag_n,
  output logic                   o_overflow_irq,
  output logic                   o_capture_irq,
  output logic                   o_compare_irq,
  output logic                   o_timer_global_irq
);
  cct_pkg::cct_state_s state_reg;
  cct_pkg::cct_state_s state_next;
  logic                pre_tick;
  logic                ext_edge;
  logic [1:0]          cap_edge;
  logic                tick;
  logic                wrap;
  logic                cnt_low_acc;
  logic                ovf_req;
  logic                cap_req;
  logic                glb;
  logic                cnt_load;
  logic                hi_any;
  logic                lo_any;
  logic                lo_only;

  cct_prescaler #(
    .PRE_W (cct_pkg::PRE_W)
  ) u_pre (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_clk_sel (i_cfg.clk_sel),
    .i_halt    (i_halt),
    .o_tick    (pre_tick)
  );

  cct_pin_sync u_ext (
    .i_sys_clk  (i_sys_clk),
    .i_srst     (i_srst),
    .i_pin      (i_external_count_input),
    .i_rise_sel (i_cfg.ext_edge_select),    // [R13]
    .o_edge     (ext_edge)
  );

  genvar gi;
  generate
    for (gi = 0; gi < cct_pkg::NUM_CAP; gi++) begin : g_cap
      cct_pin_sync u_cap (
        .i_sys_clk  (i_sys_clk),
        .i_srst     (i_srst),
        .i_pin      (i_capture_pin_n[gi]),
        .i_rise_sel (i_cfg.capture_edge_select_n[gi]),   // [R17]
        .o_edge     (cap_edge[gi])
      );
    end
  endgenerate

  // halt freezes the count; wait mode has no input and never stops it
  assign tick = !i_halt && ((i_cfg.clk_sel == cct_pkg::CLK_EXT) ?  // [R11]
                ext_edge : pre_tick);                            // [R13]
  assign wrap = tick && (state_reg.count == cct_pkg::CNT_TOP);
  assign cnt_low_acc = i_acc.rd_count_low_byte || i_acc.wr_count_low_byte;
  assign cnt_load = i_acc.wr_count_low_byte || i_acc.wr_alt_count_low_byte;
  assign hi_any   = i_acc.rd_count_high_byte || i_acc.rd_alt_count_high_byte;
  assign lo_any   = i_acc.rd_count_low_byte || i_acc.rd_alt_count_low_byte;
  assign lo_only  = lo_any && !hi_any;

  always_comb begin
    state_next = state_reg;
    state_next.rd_valid = 1'b0;

    // counter: a reload wins over a tick in the same cycle
    if (i_acc.wr_count_low_byte || i_acc.wr_alt_count_low_byte) begin
      state_next.count = cct_pkg::CNT_RESET;                    // [R4]
    end else if (tick) begin
      state_next.count = state_reg.count + cct_pkg::CNT_STEP;   // [R1] [R14]
    end

    // read port, one strobe at a time; earlier strobes take priority, except that a capture channel 1 strobe wins over channel 0
    if (i_acc.rd_count_high_byte || i_acc.rd_alt_count_high_byte) begin
      state_next.rd_data  = state_reg.count[15:8];              // [R5]
      state_next.rd_valid = 1'b1;
      if (!state_reg.buffered) begin
        state_next.lo_buf   = state_reg.count[7:0];             // [R6]
        state_next.buffered = 1'b1;
      end
    end else if (i_acc.rd_count_low_byte ||
                 i_acc.rd_alt_count_low_byte) begin
      state_next.rd_data  = state_reg.buffered ? state_reg.lo_buf  // [R6]
                            : state_reg.count[7:0];                // [R7]
      state_next.rd_valid = 1'b1;
      state_next.buffered = 1'b0;
    end else if (i_acc.rd_status_register) begin
      state_next.rd_data = cct_pkg::SR_RESET;
      state_next.rd_data[cct_pkg::SR_CAP0_BIT] = state_reg.cap_flag[0];
      state_next.rd_data[cct_pkg::SR_CAP1_BIT] = state_reg.cap_flag[1];
      state_next.rd_data[cct_pkg::SR_OVF_BIT]  = state_reg.ovf_flag;
      state_next.rd_valid = 1'b1;
    end else begin
      for (int i = 0; i < cct_pkg::NUM_CAP; i++) begin
        if (i_acc.rd_capture_high_byte_n[i]) begin
          state_next.rd_data  = state_reg.cap[i][15:8];
          state_next.rd_valid = 1'b1;
        end else if (i_acc.rd_capture_low_byte_n[i]) begin
          state_next.rd_data  = state_reg.cap[i][7:0];
          state_next.rd_valid = 1'b1;
        end
      end
    end

    // overflow flag: status read arms, counter low access clears,
    // a wrap in the same cycle wins over the clear
    if (i_acc.rd_status_register) begin
      state_next.ovf_arm = state_reg.ovf_flag;                  // [R10]
    end
    if (state_reg.ovf_arm && cnt_low_acc) begin
      state_next.ovf_flag = 1'b0;                               // [R10] [R5]
      state_next.ovf_arm  = 1'b0;
    end
    if (wrap) begin
      state_next.ovf_flag = 1'b1;                               // [R8]
    end

    for (int i = 0; i < cct_pkg::NUM_CAP; i++) begin
      if (i_acc.rd_capture_high_byte_n[i]) begin
        state_next.cap_inhibit[i] = 1'b1;                       // [R20]
      end else if (i_acc.rd_capture_low_byte_n[i]) begin
        state_next.cap_inhibit[i] = 1'b0;                       // [R20]
      end
      if (i_acc.rd_status_register) begin
        state_next.cap_arm[i] = state_reg.cap_flag[i];          // [R19]
      end
      if (state_reg.cap_arm[i] && (i_acc.rd_capture_low_byte_n[i] ||
          i_acc.wr_capture_low_byte_n[i])) begin
        state_next.cap_flag[i] = 1'b0;                          // [R19]
        state_next.cap_arm[i]  = 1'b0;
      end
      // a write to the capture low byte never alters the value
      if (cap_edge[i] && !state_reg.cap_inhibit[i]) begin
        state_next.cap[i]      = state_reg.count;               // [R16] [R21]
        state_next.cap_flag[i] = 1'b1;                          // [R16]
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg          <= '0;
      state_reg.count    <= cct_pkg::CNT_RESET;                 // [R12] [R11]
    end else begin
      state_reg <= state_next;
    end
  end

  // interrupt routing
  assign glb     = i_cfg.global_irq_route;
  assign ovf_req = state_reg.ovf_flag && i_cfg.overflow_irq_enable;
  assign cap_req = (|state_reg.cap_flag) && i_cfg.capture_irq_enable;
  assign o_overflow_irq = !glb && ovf_req &&
                          i_cfg.overflow_irq_route;               // [R9] [R22]
  assign o_capture_irq  = !glb && cap_req &&
                          i_cfg.capture_irq_route;                // [R18] [R22]
  assign o_compare_irq  = 1'b0;
  assign o_timer_global_irq = glb && (ovf_req || cap_req);      // [R9] [R18]

  assign o_rd_data        = state_reg.rd_data;
  assign o_rd_valid       = state_reg.rd_valid;
  assign o_count          = state_reg.count;
  assign o_overflow_flag  = state_reg.ovf_flag;
  assign o_capture_flag_n = state_reg.cap_flag;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_ovf_armed;
    i_acc.rd_status_register && state_reg.ovf_flag;
  endsequence

  sequence s_low_access;
    cnt_low_acc && !wrap;
  endsequence

  sequence s_hi_read;
    (i_acc.rd_count_high_byte || i_acc.rd_alt_count_high_byte) &&
    !state_reg.buffered;
  endsequence

  sequence s_lo_read_only;
    lo_only;
  endsequence

  sequence s_cap0_armed;
    i_acc.rd_status_register && state_reg.cap_flag[0];
  endsequence

  sequence s_cap0_low;
    (i_acc.rd_capture_low_byte_n[0] || i_acc.wr_capture_low_byte_n[0]) &&
    !(cap_edge[0] && !state_reg.cap_inhibit[0]);
  endsequence

  count_reload_a: assert property (   // [R4]
    (i_acc.wr_count_low_byte || i_acc.wr_alt_count_low_byte)
    |=> state_reg.count == 16'hfffc)
    else $error("counter not reloaded by low byte write");

  ovf_set_a: assert property (        // [R8]
    wrap |=> state_reg.ovf_flag && state_reg.count == 16'h0000)
    else $error("wrap did not set the overflow flag");

  ovf_clear_a: assert property (      // [R10]
    s_ovf_armed ##1 (!cnt_low_acc)[*3] ##1 s_low_access
    |=> !state_reg.ovf_flag)
    else $error("overflow flag not cleared by clearing sequence");

  ovf_alt_keep_a: assert property (   // [R5]
    state_reg.ovf_flag && !cnt_low_acc |=> state_reg.ovf_flag)
    else $error("overflow flag cleared without counter low access");

  lo_buffer_a: assert property (      // [R6]
    s_hi_read ##1 (!lo_only)[*2] ##1 s_lo_read_only
    |=> o_rd_data == $past(state_reg.count[7:0], 4))
    else $error("buffered low byte not returned");

  live_low_a: assert property (       // [R7]
    s_lo_read_only and !state_reg.buffered
    |=> o_rd_valid && o_rd_data == $past(state_reg.count[7:0]))
    else $error("live low byte not returned");

  halt_freeze_a: assert property (    // [R11]
    i_halt && !i_acc.wr_count_low_byte && !i_acc.wr_alt_count_low_byte
    |=> state_reg.count == $past(state_reg.count))
    else $error("counter moved during halt");

  cap_latch_a: assert property (      // [R16]
    cap_edge[0] && !state_reg.cap_inhibit[0]
    |=> state_reg.cap[0] == $past(state_reg.count) &&
        state_reg.cap_flag[0])
    else $error("capture did not latch the count");

  cap_block_a: assert property (      // [R20]
    state_reg.cap_inhibit[1] |=> $stable(state_reg.cap[1]))
    else $error("capture transfer while blocked");

  irq_route_a: assert property (      // [R9]
    o_overflow_irq |-> state_reg.ovf_flag && i_cfg.overflow_irq_enable &&
    i_cfg.overflow_irq_route && !o_timer_global_irq)
    else $error("overflow interrupt raised without its gate");

  irq_global_a: assert property (     // [R22]
    glb |-> !o_overflow_irq && !o_capture_irq &&
    (o_timer_global_irq == (ovf_req || cap_req)))
    else $error("global interrupt routing wrong");

  count_step_a: assert property (     // [R1]
    tick && !cnt_load
    |=> state_reg.count == 16'($past(state_reg.count) + 16'h0001))
    else $error("counter did not advance on a tick");

  count_hold_a: assert property (     // [R1]
    !tick && !cnt_load |=> $stable(state_reg.count))
    else $error("counter moved without a tick");

  ext_source_a: assert property (     // [R13]
    i_cfg.clk_sel == cct_pkg::CLK_EXT && !ext_edge && !cnt_load
    |=> $stable(state_reg.count))
    else $error("counter moved without an external edge");

  hi_data_a: assert property (        // [R5]
    hi_any |=> o_rd_valid && o_rd_data == $past(state_reg.count[15:8]))
    else $error("high byte read returned wrong data");

  buf_hold_a: assert property (       // [R6]
    state_reg.buffered && !lo_any
    |=> state_reg.buffered && $stable(state_reg.lo_buf))
    else $error("buffered low byte changed before the low read");

  ovf_source_a: assert property (     // [R8]
    $rose(state_reg.ovf_flag) |-> $past(wrap))
    else $error("overflow flag set without a wrap");

  ovf_pending_a: assert property (    // [R9]
    state_reg.ovf_flag && i_cfg.overflow_irq_enable &&
    i_cfg.overflow_irq_route && !glb |-> o_overflow_irq)
    else $error("pending overflow interrupt not raised");

  cap_pending_a: assert property (    // [R18]
    (|state_reg.cap_flag) && i_cfg.capture_irq_enable &&
    i_cfg.capture_irq_route && !glb |-> o_capture_irq)
    else $error("pending capture interrupt not raised");

  cap_gate_a: assert property (       // [R18]
    o_capture_irq |-> (|state_reg.cap_flag) && i_cfg.capture_irq_enable &&
    i_cfg.capture_irq_route)
    else $error("capture interrupt raised without its gate");

  glb_pending_a: assert property (    // [R22]
    glb && state_reg.ovf_flag && i_cfg.overflow_irq_enable
    |-> o_timer_global_irq)
    else $error("pending global interrupt not raised");

  cmp_idle_a: assert property (       // [R22]
    !o_compare_irq)
    else $error("compare interrupt raised");

  cap_source_a: assert property (     // [R16]
    $rose(state_reg.cap_flag[1]) |-> $past(cap_edge[1]))
    else $error("capture flag set without an edge");

  cap_clear_a: assert property (      // [R19]
    s_cap0_armed ##1 !i_acc.rd_capture_low_byte_n[0] ##1 s_cap0_low
    |=> !state_reg.cap_flag[0])
    else $error("capture flag not cleared by clearing sequence");

  cap_keep_a: assert property (       // [R19]
    state_reg.cap_flag[0] && !i_acc.rd_capture_low_byte_n[0] &&
    !i_acc.wr_capture_low_byte_n[0] |=> state_reg.cap_flag[0])
    else $error("capture flag cleared without a low access");
endmodule

// >>> cct_pkg.sv
package cct_pkg;
  localparam int          CNT_W       = 16;
  localparam logic [15:0] CNT_RESET   = 16'hfffc;
  localparam logic [15:0] CNT_TOP     = 16'hffff;
  localparam logic [15:0] CNT_STEP    = 16'h0001;
  localparam int          SYNC_STAGES = 3;
  localparam int          PRE_W       = 3;
  localparam int          NUM_CAP     = 2;
  localparam int          SR_CAP0_BIT = 7;
  localparam int          SR_CAP1_BIT = 6;
  localparam int          SR_OVF_BIT  = 5;
  localparam logic        EDGE_RISE   = 1'b1;
  localparam logic [7:0]  SR_RESET    = 8'h00;

  // clock select encoding of the counter source
  typedef enum logic [1:0] {
    CLK_DIV4 = 2'b00, // [R3]
    CLK_DIV2 = 2'b01,
    CLK_DIV8 = 2'b10,
    CLK_EXT  = 2'b11
  } cct_clk_sel_e;

  typedef struct packed {
    cct_clk_sel_e clk_sel;
    logic         ext_edge_select;
    logic [1:0]   capture_edge_select_n;
    logic         overflow_irq_enable;
    logic         overflow_irq_route;
    logic         capture_irq_enable;
    logic         capture_irq_route;
    logic         global_irq_route;
  } cct_cfg_s;

  typedef struct packed {
    logic       rd_count_high_byte;
    logic       rd_count_low_byte;
    logic       rd_alt_count_high_byte;
    logic       rd_alt_count_low_byte;
    logic       wr_count_low_byte;
    logic       wr_alt_count_low_byte;
    logic       rd_status_register;
    logic [1:0] rd_capture_high_byte_n;
    logic [1:0] rd_capture_low_byte_n;
    logic [1:0] wr_capture_low_byte_n;
  } cct_acc_s;

  typedef struct packed {
    logic [15:0]      count;
    logic [7:0]       lo_buf;
    logic             buffered;
    logic             ovf_flag;
    logic             ovf_arm;
    logic [1:0][15:0] cap;
    logic [1:0]       cap_flag;
    logic [1:0]       cap_arm;
    logic [1:0]       cap_inhibit;
    logic [7:0]       rd_data;
    logic             rd_valid;
  } cct_state_s;
endpackage

// >>> cct_pin_sync.sv
`timescale 1ns/100ps
module cct_pin_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  input  wire logic i_pin,
  input  wire logic i_rise_sel,
  output logic      o_edge
);
  logic [cct_pkg::SYNC_STAGES-1:0] sync_reg;
  logic                            level_reg;
  logic                            agree;

  // stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
  assign agree  = sync_reg[1] == sync_reg[2];
  assign o_edge = agree && (sync_reg[2] != level_reg) &&
                  (sync_reg[2] == i_rise_sel);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sync_reg  <= '0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[cct_pkg::SYNC_STAGES-2:0], i_pin};
      if (agree) begin
        level_reg <= sync_reg[2];
      end
    end
  end
endmodule

// >>> cct_prescaler.sv
`timescale 1ns/100ps
module cct_prescaler #(
  parameter int PRE_W = cct_pkg::PRE_W
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_srst,
  input  wire cct_pkg::cct_clk_sel_e i_clk_sel,
  input  wire logic                 i_halt,
  output logic                      o_tick
);
  logic [PRE_W-1:0] div_reg;
  logic [PRE_W-1:0] div_next;

  always_comb begin
    div_next = i_halt ? div_reg : div_reg + PRE_W'(1);
    case (i_clk_sel)
      cct_pkg::CLK_DIV2: o_tick = !i_halt && div_reg[0];     // [R2]
      cct_pkg::CLK_DIV4: o_tick = !i_halt && &div_reg[1:0];  // [R2]
      cct_pkg::CLK_DIV8: o_tick = !i_halt && &div_reg[2:0];  // [R2]
      default:           o_tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end
endmodule

// >>> cct_pin_model.sv
`timescale 1ns/100ps
module cct_pin_model (
  input  wire logic i_sys_clk,
  output logic      o_ext_pin,
  output logic [1:0] o_cap_pin
);
  initial begin
    o_ext_pin = 1'b0;
    o_cap_pin = 2'b00;
  end

  // full pulses on the count pin; half is the core clocks per level
  task automatic ext_pulses(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge i_sys_clk);
      #1 o_ext_pin = 1'b1;
      repeat (half) @(posedge i_sys_clk);
      #1 o_ext_pin = 1'b0;
    end
  endtask

  // set one capture pin, then hold it long enough to pass the sync
  task automatic cap_level(input int ch, input logic lvl);
    @(posedge i_sys_clk);
    #1 o_cap_pin[ch] = lvl;
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask
endmodule

// >>> test_capture_counter_timer.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module test_capture_counter_timer;
  // strobe index k selects bit 12-k of the access struct
  localparam int RD_HI = 0, RD_LO = 1, ALT_HI = 2, ALT_LO = 3;
  localparam int WR_LO = 4, WR_ALT = 5, RD_SR = 6;
  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic              halt = 1'b0;
  cct_pkg::cct_cfg_s cfg = '0;
  cct_pkg::cct_acc_s acc_s = '0;
  logic              ext_pin;
  logic [1:0]        cap_pin;
  logic [7:0]        rd_data;
  logic              rd_valid;
  logic [15:0]       count;
  logic              ovf;
  logic [1:0]        capf;
  logic              ovf_irq;
  logic              cap_irq;
  logic              cmp_irq;
  logic              glb_irq;
  int                bad_count = 0;
  int                n_checks = 0;
  logic [7:0]        d;
  logic [15:0]       s;
  logic [15:0]       s0;

  always #25 sys_clk = ~sys_clk;

  cct_timer uut (
    .i_sys_clk(sys_clk), .i_srst(srst), .i_cfg(cfg), .i_acc(acc_s),
    .i_halt(halt), .i_external_count_input(ext_pin),
    .i_capture_pin_n(cap_pin), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_count(count), .o_overflow_flag(ovf),
    .o_capture_flag_n(capf), .o_overflow_irq(ovf_irq),
    .o_capture_irq(cap_irq), .o_compare_irq(cmp_irq),
    .o_timer_global_irq(glb_irq)
  );

  cct_pin_model pm (
    .i_sys_clk(sys_clk), .o_ext_pin(ext_pin), .o_cap_pin(cap_pin)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one strobe cycle, then one idle cycle; s is the count it was taken at
  task automatic acc(input int k);
    acc_s = cct_pkg::cct_acc_s'(13'h1000 >> k);
    s = count;
    cyc(1);
    acc_s = '0;
    d = rd_data;
    if (k < 4 || (k > 5 && k < 11)) `CHK(rd_valid, 1'b1)
    cyc(1);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // w = 2 waits for overflow, else for capture flag w
  task automatic waitf(input int w);
    int i;
    for (i = 0; i < 60; i++) begin
      if ((w == 2 ? ovf : capf[w]) === 1'b1) break;
      cyc(1);
    end
    if (i == 60) begin
      bad_count++;
      end_of_test();
    end
  endtask

  initial begin
    cyc(20);
    `CHK(count, cct_pkg::CNT_RESET)
    `CHK({ovf, capf, ovf_irq, cap_irq, glb_irq}, 6'h00)
    srst = 1'b0;
    waitf(2);
    `CHK(count, 16'h0000)
    `CHK(ovf_irq, 1'b0)
    cfg.overflow_irq_enable = 1'b1;
    cyc(1);
    `CHK(ovf_irq, 1'b0)
    cfg.overflow_irq_route = 1'b1;
    cyc(1);
    `CHK(ovf_irq, 1'b1)
    cfg.global_irq_route = 1'b1;
    cyc(1);
    `CHK({ovf_irq, glb_irq}, 2'b01)
    cfg.global_irq_route = 1'b0;
    for (int j = 0; j < 3; j++) begin
      cfg.clk_sel = cct_pkg::cct_clk_sel_e'(j[1:0]);
      acc(j == 1 ? WR_ALT : WR_LO);
      s0 = count;
      cyc(16);
      `CHK(count - s0, 16'(j == 0 ? 4 : (j == 1 ? 8 : 2)))
    end
    cfg.clk_sel = cct_pkg::CLK_DIV2;
    acc(RD_HI);
    s0 = s;
    `CHK(d, s0[15:8])
    cyc(5);
    acc(ALT_HI);
    `CHK(d, s[15:8])
    acc(RD_LO);
    `CHK(d, s0[7:0])
    acc(ALT_LO);
    `CHK(d, s[7:0])
    acc(RD_HI);
    s0 = s;
    cyc(1);
    acc(RD_LO);
    `CHK(d, s0[7:0])
    halt = 1'b1;
    acc(WR_ALT);
    `CHK(count, cct_pkg::CNT_RESET)
    cyc(10);
    `CHK(count, cct_pkg::CNT_RESET)
    acc(RD_LO);
    `CHK(ovf, 1'b1)
    acc(RD_SR);
    `CHK(d, 8'h20)
    acc(ALT_LO);
    `CHK(ovf, 1'b1)
    acc(RD_LO);
    `CHK(ovf, 1'b0)
    halt = 1'b0;
    cfg.clk_sel = cct_pkg::CLK_EXT;
    cfg.ext_edge_select = 1'b1;
    for (int j = 0; j < 2; j++) begin
      acc(WR_LO);
      cyc(12);
      `CHK(count, cct_pkg::CNT_RESET)
      pm.ext_pulses(3, 4 + 2 * j);
      cyc(8);
      `CHK(count, 16'hffff)
      cfg.ext_edge_select = 1'b0;
    end
    halt = 1'b1;
    acc(WR_LO);
    cfg.capture_edge_select_n = 2'b01;
    cfg.capture_irq_enable = 1'b1;
    cfg.capture_irq_route = 1'b1;
    pm.cap_level(1, 1'b1);
    `CHK(capf, 2'b00)
    pm.cap_level(0, 1'b1);
    waitf(0);
    pm.cap_level(1, 1'b0);
    waitf(1);
    `CHK(cap_irq, 1'b1)
    `CHK(cmp_irq, 1'b0)
    for (int ch = 0; ch < 2; ch++) begin
      acc(8 - ch);
      `CHK(d, 8'hff)
      acc(RD_SR);
      `CHK(d, ch == 0 ? 8'hc0 : 8'h40)
      acc(10 - ch);
      `CHK(d, 8'hfc)
      `CHK(capf[ch], 1'b0)
    end
    `CHK(cap_irq, 1'b0)
    cfg.clk_sel = cct_pkg::CLK_DIV2;
    acc(8);
    halt = 1'b0;
    cyc(3);
    halt = 1'b1;
    pm.cap_level(0, 1'b0);
    pm.cap_level(0, 1'b1);
    `CHK(capf[0], 1'b0)
    acc(10);
    `CHK(d, 8'hfc)
    s0 = count;
    pm.cap_level(0, 1'b0);
    pm.cap_level(0, 1'b1);
    waitf(0);
    acc(8);
    `CHK(d, s0[15:8])
    acc(10);
    `CHK(d, s0[7:0])
    acc(RD_SR);
    acc(12);
    `CHK(capf[0], 1'b0)
    srst = 1'b1;
    cyc(2);
    `CHK(count, cct_pkg::CNT_RESET)
    end_of_test();
  end
endmodule
